// *** src/epvp_defines.vh ***
// Register offsets, field positions and reset values for the pin request and vector block.
// Assumes an 8-bit register port with a 4-bit address, included by bare name.
`ifndef EPVP_DEFINES_VH
`define EPVP_DEFINES_VH

// Register offsets.
`define EPVP_OFS_PRSC 4'h0
`define EPVP_OFS_EVT_STATUS 4'h1
`define EPVP_OFS_EVT_MASK 4'h2
`define EPVP_OFS_PIN_STATE 4'h3
`define EPVP_OFS_PEND_VEC 4'h4

// Fields of pin_request_status_control.
`define EPVP_PRSC_MODE 0
`define EPVP_PRSC_PIE 1
`define EPVP_PRSC_ACK 2
`define EPVP_PRSC_FLAG 3
`define EPVP_PRSC_PE 4
`define EPVP_PRSC_POL 5
`define EPVP_PRSC_PDD 6

// Fields of the event status and mask registers.
`define EPVP_EVT_PIN 0
`define EPVP_EVT_WAKE 1
`define EPVP_EVT_W 2

// Fields of the pin state register.
`define EPVP_PST_LEVEL 0
`define EPVP_PST_ASSERTED 1
`define EPVP_PST_PULL_EN 2
`define EPVP_PST_PULL_UP 3

// Field of the pending vector register.
`define EPVP_PV_VALID 7

// Reset values.
`define EPVP_RST_PRSC 8'h00
`define EPVP_RST_EVT 2'h0
`define EPVP_RST_VEC 5'h00

// Vector numbers and vector table base.
`define EPVP_VEC_RESET 0
`define EPVP_VEC_SWI 1
`define EPVP_VEC_PIN 2
`define EPVP_VEC_FIRST_PERIPH 3
`define EPVP_VEC_TOP 16'hfffe

`endif

// *** src/epvp_irq_ctrl.v ***
// External interrupt request pin logic and fixed-priority vector selection.
// Assumes the bus port and all CPU-side inputs are synchronous to ref_clk; only pin_in is async.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "epvp_defines.vh"

module epvp_irq_ctrl (
   // Clock, reset and clock enable.
   input wire ref_clk,
   input wire arst_n,
   input wire clk_en,
   // Register port.
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_r,
   // External request pin and its pull device.
   input wire pin_in,
   output reg pull_en_r,
   output reg pull_up_r,
   // Stop mode and asynchronous wake.
   input wire stop_mode,
   output reg stop_wake_r,
   // Pin level seen by the branch instructions.
   output reg branch_on_pin_high_r,
   output reg branch_on_pin_low_r,
   // Interrupt sources other than the pin.
   input wire reset_req,
   input wire software_interrupt_instruction,
   input wire [31:3] src_flag,
   input wire [31:3] src_local_en,
   // CPU side.
   input wire global_mask,
   output reg cpu_int_r,
   output reg [4:0] vec_num_r,
   output reg [15:0] vec_addr_high_r,
   output reg [15:0] vec_addr_low_r,
   // Block interrupt from the event status register.
   output reg evt_irq_r
);

   // Lowest set bit wins, so the loop runs downward and the last hit is kept.
   function [5:0] epvp_prio;
      input [31:0] req;
      integer i;
      begin
         epvp_prio = 6'h00;
         for (i = 31; i >= 0; i = i - 1) begin
            if (req[i]) begin
               epvp_prio = {1'b1, i[4:0]};
            end
         end
      end
   endfunction

   // Address of the high byte of a vector; the low byte follows it.
   function [15:0] epvp_vec_addr;
      input [4:0] num;
      begin
         epvp_vec_addr = `EPVP_VEC_TOP - {10'h000, num, 1'b0};
      end
   endfunction

   // Polarity zero counts a low level as asserted, one a high level.
   function epvp_asserted;
      input pol;
      input level;
      begin
         epvp_asserted = pol ? level : ~level;
      end
   endfunction

   reg pin_s1_r;
   reg pin_s2_r;
   reg asserted_prev_r;
   reg mode_r;
   reg pie_r;
   reg pe_r;
   reg pol_r;
   reg pdd_r;
   reg flag_r;
   reg [`EPVP_EVT_W-1:0] evt_status_r;
   reg [`EPVP_EVT_W-1:0] evt_mask_r;
   reg wake_s1_r;
   reg wake_s2_r;
   reg wake_prev_r;
   reg wake_async_r;
   reg [7:0] rdata_nxt;
   reg flag_nxt;
   reg [`EPVP_EVT_W-1:0] evt_status_nxt;

   wire prsc_wr = reg_wr && (reg_addr == `EPVP_OFS_PRSC);
   wire status_wr = reg_wr && (reg_addr == `EPVP_OFS_EVT_STATUS);
   wire mask_wr = reg_wr && (reg_addr == `EPVP_OFS_EVT_MASK);

   // Polarity zero counts a low pin as asserted.
   wire pin_asserted = epvp_asserted(pol_r, pin_s2_r);
   wire pin_edge = pin_asserted & ~asserted_prev_r;
   // With pe_r set the edge counts in both modes; the level counts only in edge-and-level mode.
   wire pin_event = pe_r & (pin_edge | (mode_r & pin_asserted));
   // The acknowledge cannot clear while the level holds the flag.
   wire ack_clear = prsc_wr & reg_wdata[`EPVP_PRSC_ACK] & ~(mode_r & pin_asserted);
   wire pin_new_event = pe_r & pin_edge;
   wire wake_event = wake_s2_r & ~wake_prev_r;

   // Qualified requests: pin needs its enable, peripherals their local enable.
   wire [31:0] pend_vec = {src_flag & src_local_en, flag_r & pie_r,
                           software_interrupt_instruction, reset_req};
   wire [5:0] winner = epvp_prio(pend_vec);

   // Asynchronous wake while clocks are stopped. The gated source may glitch when
   // configuration changes, which is harmless because the latch is cleared on leaving stop.
   wire wake_src = stop_mode & pe_r & epvp_asserted(pol_r, pin_in);
   wire wake_clr_n = arst_n & stop_mode;

   always @(posedge wake_src or negedge wake_clr_n) begin
      if (!wake_clr_n) begin
         wake_async_r <= 1'b0;
      end else begin
         wake_async_r <= 1'b1;
      end
   end

   always @* begin
      flag_nxt = flag_r;
      if (ack_clear) begin
         flag_nxt = 1'b0;
      end
      if (pin_event) begin
         flag_nxt = 1'b1;
      end
   end

   always @* begin
      evt_status_nxt = evt_status_r;
      if (status_wr) begin
         evt_status_nxt = evt_status_r & ~reg_wdata[`EPVP_EVT_W-1:0];
      end
      // A new event in the clearing cycle still lands.
      if (pin_new_event) begin
         evt_status_nxt[`EPVP_EVT_PIN] = 1'b1;
      end
      if (wake_event) begin
         evt_status_nxt[`EPVP_EVT_WAKE] = 1'b1;
      end
   end

   always @* begin
      rdata_nxt = 8'h00;
      if (reg_addr == `EPVP_OFS_PRSC) begin
         rdata_nxt[`EPVP_PRSC_MODE] = mode_r;
         rdata_nxt[`EPVP_PRSC_PIE] = pie_r;
         rdata_nxt[`EPVP_PRSC_FLAG] = flag_r;
         rdata_nxt[`EPVP_PRSC_PE] = pe_r;
         rdata_nxt[`EPVP_PRSC_POL] = pol_r;
         rdata_nxt[`EPVP_PRSC_PDD] = pdd_r;
      end else if (reg_addr == `EPVP_OFS_EVT_STATUS) begin
         rdata_nxt[`EPVP_EVT_W-1:0] = evt_status_r;
      end else if (reg_addr == `EPVP_OFS_EVT_MASK) begin
         rdata_nxt[`EPVP_EVT_W-1:0] = evt_mask_r;
      end else if (reg_addr == `EPVP_OFS_PIN_STATE) begin
         rdata_nxt[`EPVP_PST_LEVEL] = pin_s2_r;
         rdata_nxt[`EPVP_PST_ASSERTED] = pin_asserted;
         rdata_nxt[`EPVP_PST_PULL_EN] = pull_en_r;
         rdata_nxt[`EPVP_PST_PULL_UP] = pull_up_r;
      end else if (reg_addr == `EPVP_OFS_PEND_VEC) begin
         rdata_nxt[`EPVP_PV_VALID] = winner[5];
         rdata_nxt[4:0] = winner[4:0];
      end
   end

   // Pin synchroniser; only the second flop feeds any logic.
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         asserted_prev_r <= 1'b0;
      end else if (clk_en) begin
         pin_s1_r <= pin_in;
         pin_s2_r <= pin_s1_r;
         asserted_prev_r <= pin_asserted;
      end
   end

   // The wake latch is not timed by ref_clk, so it is synchronised like the pin.
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_s1_r <= 1'b0;
         wake_s2_r <= 1'b0;
         wake_prev_r <= 1'b0;
         stop_wake_r <= 1'b0;
      end else if (clk_en) begin
         wake_s1_r <= wake_async_r;
         wake_s2_r <= wake_s1_r;
         wake_prev_r <= wake_s2_r;
         stop_wake_r <= wake_s2_r;
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_r <= 1'b0;
         pie_r <= 1'b0;
         pe_r <= 1'b0;
         pol_r <= 1'b0;
         pdd_r <= 1'b0;
      end else if (clk_en) begin
         if (prsc_wr) begin
            mode_r <= reg_wdata[`EPVP_PRSC_MODE];
            pie_r <= reg_wdata[`EPVP_PRSC_PIE];
            pe_r <= reg_wdata[`EPVP_PRSC_PE];
            pol_r <= reg_wdata[`EPVP_PRSC_POL];
            pdd_r <= reg_wdata[`EPVP_PRSC_PDD];
         end
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_r <= 1'b0;
         evt_status_r <= `EPVP_RST_EVT;
         evt_mask_r <= `EPVP_RST_EVT;
         evt_irq_r <= 1'b0;
      end else if (clk_en) begin
         if (mask_wr) begin
            evt_mask_r <= reg_wdata[`EPVP_EVT_W-1:0];
         end
         flag_r <= flag_nxt;
         evt_status_r <= evt_status_nxt;
         evt_irq_r <= |(evt_status_nxt & evt_mask_r);
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_r <= 8'h00;
      end else if (clk_en) begin
         // Acknowledge is write-only and never stored, so it reads back as zero.
         if (reg_rd) begin
            reg_rdata_r <= rdata_nxt;
         end else begin
            reg_rdata_r <= 8'h00;
         end
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pull_en_r <= 1'b0;
         pull_up_r <= 1'b0;
         branch_on_pin_high_r <= 1'b0;
         branch_on_pin_low_r <= 1'b0;
      end else if (clk_en) begin
         pull_en_r <= pe_r & ~pdd_r;
         pull_up_r <= ~pol_r;
         branch_on_pin_high_r <= pe_r & pin_s2_r;
         branch_on_pin_low_r <= pe_r & ~pin_s2_r;
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_int_r <= 1'b0;
         vec_num_r <= `EPVP_RST_VEC;
         vec_addr_high_r <= `EPVP_VEC_TOP;
         vec_addr_low_r <= `EPVP_VEC_TOP + 16'h0001;
      end else if (clk_en) begin
         // Reset is never masked; the rest waits for the global mask to clear.
         cpu_int_r <= reset_req | (winner[5] & ~global_mask);
         vec_num_r <= winner[4:0];
         vec_addr_high_r <= epvp_vec_addr(winner[4:0]);
         vec_addr_low_r <= epvp_vec_addr(winner[4:0]) + 16'h0001;
      end
   end

endmodule // epvp_irq_ctrl
`default_nettype wire

// *** dv/epvp_irq_props.sv ***
// Checker for the pin request and vector block.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module epvp_irq_props (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // Request inputs.
   input wire logic stop_mode,
   input wire logic reset_req,
   input wire logic software_interrupt_instruction,
   input wire logic [31:3] src_flag,
   input wire logic [31:3] src_local_en,
   input wire logic global_mask,
   // Watched outputs.
   input wire logic stop_wake_r,
   input wire logic cpu_int_r,
   input wire logic [4:0] vec_num_r,
   input wire logic [15:0] vec_addr_high_r,
   input wire logic [15:0] vec_addr_low_r
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   wire [31:0] req_w = {src_flag & src_local_en, 3'b000};
   sequence run_s;
      clk_en && !reset_req;
   endsequence
   addr_pair_a: assert property (vec_addr_low_r == vec_addr_high_r + 16'h0001)
      else $error("vector byte pair broken");
   addr_map_a: assert property (vec_addr_high_r == 16'hfffe - {10'h000, vec_num_r, 1'b0})
      else $error("vector address wrong");
   reset_win_a: assert property (clk_en && reset_req |=> cpu_int_r && vec_num_r == 5'd0)
      else $error("reset not first");
   swi_prio_a: assert property (run_s ##0 software_interrupt_instruction |=> vec_num_r == 5'd1)
      else $error("software vector lost");
   mask_block_a: assert property (run_s ##0 global_mask |=> !cpu_int_r)
      else $error("masked request passed");
   req_raise_a: assert property (run_s ##0 !global_mask && req_w != 0 |=> cpu_int_r)
      else $error("request not raised");
   src_win_a: assert property (vec_num_r > 5'd2 |->
      ($past(req_w) & ((32'h2 << vec_num_r) - 32'h1)) == (32'h1 << vec_num_r))
      else $error("wrong winner");
   wake_clr_a: assert property ((!stop_mode) [*3] |=> !stop_wake_r)
      else $error("wake outside stop");
endmodule // epvp_irq_props
bind epvp_irq_ctrl epvp_irq_props i_props (.*);
`default_nettype wire

// *** dv/epvp_pin_dev.sv ***
// External device on the request pin.
// Assumes the bench commands drive_en and drive_val; a released pin follows the pull when pull_en_r is set.
`timescale 1ns/10ps
`default_nettype none
module epvp_pin_dev (
   // Commands.
   input wire logic drive_en,
   input wire logic drive_val,
   // Pull device of the block.
   input wire logic pull_en_r,
   input wire logic pull_up_r,
   // Pin.
   output logic pin
);
   logic last_r = 1'b0;
   always @(drive_en, drive_val) if (drive_en) last_r = drive_val;
   // A floating pin shows the inverse of its last value so a stale level cannot pass.
   assign pin = drive_en ? drive_val : pull_en_r ? pull_up_r : ~last_r;
endmodule // epvp_pin_dev
`default_nettype wire

// *** dv/test_ext_irq_pin_and_vector_priority.sv ***
// Self-checking bench for the pin request and vector block.
// Assumes the design header is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "epvp_defines.vh"
module test_ext_irq_pin_and_vector_priority;
   logic ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, exp_q[$];
   logic reset_req = 1'b0, software_interrupt_instruction = 1'b0, global_mask = 1'b1;
   logic [31:3] src_flag = 29'h0, src_local_en = 29'h0;
   logic drv_en = 1'b0, drv_val = 1'b0;
   logic [31:0] r, s, t;
   logic stop_mode = 1'b0;
   wire pin_in, pull_en_r, pull_up_r, stop_wake_r, cpu_int_r, evt_irq_r;
   wire branch_on_pin_high_r, branch_on_pin_low_r;
   wire [7:0] reg_rdata_r;
   wire [4:0] vec_num_r;
   wire [15:0] vec_addr_high_r, vec_addr_low_r;
   wire clk_en = 1'b1;
   wire [7:0] lv_w = {3'h0, stop_wake_r, branch_on_pin_high_r, branch_on_pin_low_r, cpu_int_r,
      evt_irq_r};
   int n_fail = 0, num_checks = 0, seed = 32'h410c;
   always #2.5 ref_clk = ~ref_clk;
   epvp_irq_ctrl i_dut (.*);
   epvp_pin_dev i_dev (.drive_en(drv_en), .drive_val(drv_val), .pull_en_r(pull_en_r),
      .pull_up_r(pull_up_r), .pin(pin_in));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask
   task automatic drive(input logic en, input logic v);
      @(posedge ref_clk);
      drv_en <= en;
      drv_val <= v;
      repeat (6) @(posedge ref_clk);
   endtask
   // Levels are sampled after the registered outputs have taken the last write.
   task automatic lv(input logic [7:0] e);
      repeat (2) @(posedge ref_clk);
      #1;
      chk(lv_w, e);
   endtask
   always @(posedge ref_clk) rd_q <= reg_rd;
   always @(negedge ref_clk) if (rd_q) chk(reg_rdata_r, exp_q.pop_front());
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      report_and_stop;
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(`EPVP_OFS_PRSC, 8'h00);
      rd(4'hf, 8'h00);
      global_mask <= 1'b0;
      wr(`EPVP_OFS_EVT_MASK, 8'h01);
      wr(`EPVP_OFS_PRSC, 8'h12);
      lv(8'h08);
      rd(`EPVP_OFS_PIN_STATE, 8'h0d);
      drive(1'b1, 1'b0);
      lv(8'h07);
      rd(`EPVP_OFS_PRSC, 8'h1a);
      rd(`EPVP_OFS_PEND_VEC, 8'h82);
      wr(`EPVP_OFS_PRSC, 8'h16);
      rd(`EPVP_OFS_PRSC, 8'h12);
      lv(8'h05);
      wr(`EPVP_OFS_EVT_MASK, 8'h00);
      lv(8'h04);
      wr(`EPVP_OFS_EVT_MASK, 8'h01);
      lv(8'h05);
      wr(`EPVP_OFS_EVT_STATUS, 8'h01);
      lv(8'h04);
      wr(`EPVP_OFS_PRSC, 8'h13);
      drive(1'b1, 1'b1);
      drive(1'b1, 1'b0);
      wr(`EPVP_OFS_PRSC, 8'h17);
      rd(`EPVP_OFS_PRSC, 8'h1b);
      drive(1'b1, 1'b1);
      wr(`EPVP_OFS_PRSC, 8'h17);
      rd(`EPVP_OFS_PRSC, 8'h13);
      wr(`EPVP_OFS_PRSC, 8'h32);
      rd(`EPVP_OFS_PIN_STATE, 8'h07);
      drive(1'b0, 1'b0);
      wr(`EPVP_OFS_PRSC, 8'h36);
      drive(1'b1, 1'b1);
      rd(`EPVP_OFS_PRSC, 8'h3a);
      wr(`EPVP_OFS_PRSC, 8'h72);
      rd(`EPVP_OFS_PIN_STATE, 8'h03);
      wr(`EPVP_OFS_PRSC, 8'h04);
      wr(`EPVP_OFS_EVT_STATUS, 8'h03);
      drive(1'b1, 1'b0);
      drive(1'b1, 1'b1);
      rd(`EPVP_OFS_PRSC, 8'h00);
      lv(8'h00);
      wr(`EPVP_OFS_PRSC, 8'h10);
      stop_mode <= 1'b1;
      drive(1'b1, 1'b0);
      lv(8'h15);
      stop_mode <= 1'b0;
      rd(`EPVP_OFS_EVT_STATUS, 8'h03);
      lv(8'h05);
      repeat (40) begin
         @(posedge ref_clk);
         r = $random(seed);
         s = $random(seed);
         t = $random(seed);
         src_flag <= s[31:3];
         src_local_en <= t[31:3];
         global_mask <= r[0];
         software_interrupt_instruction <= r[1] & r[2];
         reset_req <= r[3] & r[4] & r[5];
      end
      src_flag <= 29'h4;
      src_local_en <= 29'h1fffffff;
      reset_req <= 1'b0;
      software_interrupt_instruction <= 1'b0;
      rd(`EPVP_OFS_PEND_VEC, 8'h85);
      chk(vec_addr_high_r[7:0], 8'hf4);
      report_and_stop;
   end
endmodule // test_ext_irq_pin_and_vector_priority
`default_nettype wire
